// file: logic/smb_pkg.sv
// shared constants and types of the burst-per-step serial master
// assumes a 10 MHz system clock and step triggers from logic on that clock
`default_nettype none

package smb_pkg;

  localparam int LANES          = 4;
  localparam int WORD_MAX       = 16;
  localparam int TX_W           = LANES * WORD_MAX;
  localparam int FIFO_DEPTH     = 8;
  localparam int SYNC_W         = LANES + 1;

  // time base
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_NS        = 4;
  localparam int SCLK_MIN_HZ    = 20000;
  localparam int SCLK_MAX_HZ    = 40000000;
  // half period limits in 4 ns ticks, derived from the frequency range
  localparam int HP_TICKS_MAX   = 1000000000 / (2 * SCLK_MIN_HZ * TICK_NS);
  localparam int HP_TICKS_MIN   = (1000000000 + 2 * SCLK_MAX_HZ * TICK_NS - 1)
                                  / (2 * SCLK_MAX_HZ * TICK_NS);

  // counter widths and fixed counts
  localparam int EDGE_W         = 12;
  localparam int HP_W           = 16;
  localparam int DLY_W          = 24;
  localparam int PH_W           = 9;
  localparam logic [6:0] WORDS_MAX       = 7'h7F;
  localparam logic [4:0] BITS_WIDE       = 5'h10;
  localparam logic [4:0] BITS_NARROW     = 5'h08;
  localparam logic [2:0] LANES_MAX       = 3'h4;
  localparam logic [3:0] SETTLE_CYCLES   = 4'h4;

  // mode codes as {idle level, phase select}
  localparam logic [1:0] MODE_IDLE_LOW_SAMPLE_RISE  = 2'h0;
  localparam logic [1:0] MODE_IDLE_LOW_SAMPLE_FALL  = 2'h1;
  localparam logic [1:0] MODE_IDLE_HIGH_SAMPLE_FALL = 2'h2;
  localparam logic [1:0] MODE_IDLE_HIGH_SAMPLE_RISE = 2'h3;

  typedef enum logic [1:0] {
    SMB_START_ASAP,
    SMB_START_LATE,
    SMB_START_MANUAL
  } smb_start_t;

  typedef enum logic [2:0] {
    SMB_ST_IDLE,
    SMB_ST_DELAY,
    SMB_ST_LEAD,
    SMB_ST_SHIFT,
    SMB_ST_TRAIL,
    SMB_ST_SETTLE
  } smb_state_t;

endpackage

`default_nettype wire

// file: logic/smb_sync.sv
// two-stage synchroniser for a group of pin inputs
// assumes each bit is an independent level; no bus coherence
`default_nettype none

module smb_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // pins and synchronised levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smb_sync_st_t;

  smb_sync_st_t q;
  smb_sync_st_t d;

  always_comb begin
    d    = q;
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;

endmodule

`default_nettype wire

// file: logic/smb_fifo.sv
// small first-word-fall-through fifo with valid/ready on both sides
// depth must be a power of two so the pointers wrap by themselves
`default_nettype none

module smb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  // drain side
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic      [W-1:0] rd_data
);

  localparam int AW = $clog2(D);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                full;
  } smb_fifo_st_t;

  smb_fifo_st_t q;
  smb_fifo_st_t d;
  logic         push;
  logic         pop;

  always_comb begin
    d    = q;
    push = wr_valid && !q.full;
    pop  = rd_ready && (q.cnt != '0);
    if (push) begin
      d.mem[q.wp] = wr_data;
      d.wp        = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt  = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.full = (d.cnt == CNT_FULL);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wr_ready = !q.full;
  assign rd_valid = (q.cnt != '0);
  assign rd_data  = q.mem[q.rp];

endmodule

`default_nettype wire

// file: logic/smb_master.sv
// serial master that runs one burst of words per step trigger
// assumes configuration inputs stay still while busy is high
// Operation
// - one clock burst per step, data on edges
// - chip select low through whole burst
// - up to four data lanes, shared clock
// - lane count setting enables lanes
// - words per step configurable, at most 127
// - clock phase set in 4 ns steps, rounded to whole clock cycles
// - lead delay periods before first edge
// - trail delay periods before chip select release
// - start: asap, late computed, or manual delay
// - clock idle level follows polarity
// - drive and capture edges per mode
// - word length eight or sixteen bits
// - bit order selects lsb or msb first
// - feedback clock samples data when enabled
// - valid only when feedback edge count matches
// - mismatch clears valid, received data held
// - feedback disabled keeps valid at one
// - unused outputs are left undriven
// - feedback advised for long round trip
`default_nettype none

module smb_master (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // step and configuration
  input  wire logic                        step_trig,
  input  wire logic                        clock_idle_level,
  input  wire logic                        clock_phase_select,
  input  wire logic                        word_wide,
  input  wire logic                        lsb_first,
  input  wire logic [2:0]                  lane_count,
  input  wire logic [6:0]                  words_per_step,
  input  wire logic [1:0]                  start_sel,
  input  wire logic [smb_pkg::DLY_W-1:0]   manual_delay_cycles,
  input  wire logic [smb_pkg::DLY_W-1:0]   step_cycles,
  input  wire logic [7:0]                  lead_periods,
  input  wire logic [7:0]                  trail_periods,
  input  wire logic [smb_pkg::HP_W-1:0]    half_period_ticks,
  input  wire logic                        fb_enable,
  input  wire logic                        sclk_used,
  input  wire logic                        cs_used,
  input  wire logic [smb_pkg::LANES-1:0]   dout_used,
  // transmit stream
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  input  wire logic [smb_pkg::TX_W-1:0]    tx_data,
  // serial pins
  output logic                             sclk_o,
  output logic                             sclk_oe,
  output logic                             cs_n_o,
  output logic                             cs_n_oe,
  output logic [smb_pkg::LANES-1:0]        dout_o,
  output logic [smb_pkg::LANES-1:0]        dout_oe,
  input  wire logic [smb_pkg::LANES-1:0]   din_i,
  input  wire logic                        fb_clk_i,
  // receive results
  output logic [smb_pkg::TX_W-1:0]         rx_data,
  output logic                             rx_valid,
  output logic                             busy
);

  typedef struct packed {
    smb_pkg::smb_state_t                    state;
    logic [smb_pkg::HP_W-1:0]               hp;
    logic [smb_pkg::HP_W-1:0]               hcnt;
    logic [smb_pkg::PH_W-1:0]               phc;
    logic [smb_pkg::DLY_W-1:0]              dcnt;
    logic [3:0]                             scnt;
    logic [smb_pkg::EDGE_W-1:0]             edge_tot;
    logic [smb_pkg::EDGE_W-1:0]             edge_idx;
    logic [smb_pkg::EDGE_W-1:0]             fb_cnt;
    logic [4:0]                             tx_bit;
    logic [4:0]                             rx_bit;
    logic [1:0]                             cap_pipe;
    logic                                   fb_prev;
    logic [smb_pkg::LANES-1:0][15:0]        tx_sh;
    logic [smb_pkg::LANES-1:0][15:0]        rx_sh;
    logic [smb_pkg::LANES-1:0][15:0]        rx_hold;
    logic [smb_pkg::LANES-1:0][15:0]        rx_out;
    logic                                   valid;
    logic                                   sclk;
    logic                                   sclk_oe;
    logic                                   cs_n;
    logic                                   cs_n_oe;
    logic [smb_pkg::LANES-1:0]              dout;
    logic [smb_pkg::LANES-1:0]              dout_oe;
    logic                                   busy;
  } smb_st_t;

  smb_st_t q;
  smb_st_t d;

  logic                      fifo_valid;
  logic                      fifo_pop;
  logic [smb_pkg::TX_W-1:0]  fifo_data;
  logic [smb_pkg::SYNC_W-1:0] pin_sync;

  ////////////////////////////////////////////////////////////////////////////
  // tx fifo: the source stalls on tx_ready once eight words wait

  smb_fifo #(
    .W (smb_pkg::TX_W),
    .D (smb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wr_valid (tx_valid),
    .wr_ready (tx_ready),
    .wr_data  (tx_data),
    .rd_valid (fifo_valid),
    .rd_ready (fifo_pop),
    .rd_data  (fifo_data)
  );

  // feedback clock and data pins are foreign to sys_clk
  smb_sync #(
    .W (smb_pkg::SYNC_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .async_i ({fb_clk_i, din_i}),
    .sync_o  (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [4:0]  bits;
  logic [3:0]  top_bit;
  logic        cap_rise;
  logic        half_done;
  logic        leading;
  logic        last_bit;
  logic        own_cap;
  logic        cap_now;
  logic        fb_edge;
  logic        fb_s;
  logic [31:0] hp_calc;
  logic [31:0] burst_len;
  logic [31:0] late_dly;

  function automatic logic pick(input logic [15:0] sh, input logic lsb, input logic [3:0] tb);
    pick = lsb ? sh[0] : sh[tb];
  endfunction

  function automatic logic [15:0] shift(input logic [15:0] sh, input logic lsb);
    shift = lsb ? {1'b0, sh[15:1]} : {sh[14:0], 1'b0};
  endfunction

  always_comb begin
    d         = q;
    fifo_pop  = 1'b0;
    own_cap   = 1'b0;
    leading   = 1'b0;
    last_bit  = 1'b0;
    bits      = word_wide ? smb_pkg::BITS_WIDE : smb_pkg::BITS_NARROW;
    top_bit   = 4'(bits - 5'h01);
    cap_rise  = (clock_idle_level == clock_phase_select);
    fs_assign: begin
      fb_s    = pin_sync[smb_pkg::LANES];
    end
    fb_edge   = fb_s ^ q.fb_prev;
    half_done = (q.hcnt == '0);
    // phase length given in 4 ns ticks, rounded to nearest whole clock cycle
    hp_calc   = (32'(half_period_ticks) * 32'(smb_pkg::TICK_NS)
                 + 32'(smb_pkg::CLK_PERIOD_NS / 2)) / 32'(smb_pkg::CLK_PERIOD_NS);
    if (hp_calc == 32'h0) begin
      hp_calc = 32'h1;
    end
    burst_len = hp_calc * (32'(lead_periods) * 32'h2 + 32'(trail_periods) * 32'h2
                + 32'(words_per_step) * 32'(bits) * 32'h2) + 32'(smb_pkg::SETTLE_CYCLES);
    late_dly  = (32'(step_cycles) > burst_len) ? 32'(step_cycles) - burst_len : 32'h0;

    d.fb_prev  = fb_s;
    d.sclk_oe  = sclk_used;
    d.cs_n_oe  = cs_used;
    for (int i = 0; i < smb_pkg::LANES; i++) begin
      d.dout_oe[i] = dout_used[i] && (3'(i) < lane_count);
    end
    if (fb_edge && q.state != smb_pkg::SMB_ST_IDLE && q.fb_cnt != '1) begin
      d.fb_cnt = q.fb_cnt + 1'b1;
    end

    case (q.state)
      smb_pkg::SMB_ST_IDLE: begin
        d.sclk = clock_idle_level;
        d.cs_n = 1'b1;
        if (step_trig && words_per_step != 7'h00) begin
          d.hp       = smb_pkg::HP_W'(hp_calc);
          d.edge_tot = smb_pkg::EDGE_W'(32'(words_per_step) * 32'(bits) * 32'h2);
          d.fb_cnt   = '0;
          d.busy     = 1'b1;
          d.state    = smb_pkg::SMB_ST_DELAY;
          case (smb_pkg::smb_start_t'(start_sel))
            smb_pkg::SMB_START_LATE:   d.dcnt = smb_pkg::DLY_W'(late_dly);
            smb_pkg::SMB_START_MANUAL: d.dcnt = manual_delay_cycles;
            default:                   d.dcnt = '0;
          endcase
        end
      end
      smb_pkg::SMB_ST_DELAY: begin
        if (q.dcnt != '0) begin
          d.dcnt = q.dcnt - 1'b1;
        end else if (start_sel != 2'(smb_pkg::SMB_START_ASAP) || fifo_valid) begin
          d.cs_n     = 1'b0;
          d.state    = smb_pkg::SMB_ST_LEAD;
          d.hcnt     = q.hp - 1'b1;
          d.phc      = {lead_periods, 1'b0};
          d.edge_idx = '0;
          d.tx_bit   = '0;
          d.rx_bit   = '0;
          fifo_pop   = fifo_valid;
          for (int i = 0; i < smb_pkg::LANES; i++) begin
            d.tx_sh[i] = fifo_valid ? fifo_data[i*16 +: 16] : 16'h0000;
            if (!clock_phase_select) begin
              d.dout[i] = pick(d.tx_sh[i], lsb_first, top_bit);
            end
          end
        end
      end
      smb_pkg::SMB_ST_LEAD: begin
        d.hcnt = half_done ? q.hp - 1'b1 : q.hcnt - 1'b1;
        if (half_done) begin
          if (q.phc == '0) begin
            d.state = smb_pkg::SMB_ST_SHIFT;
          end else begin
            d.phc = q.phc - 1'b1;
          end
        end
      end
      smb_pkg::SMB_ST_SHIFT: begin
        d.hcnt = half_done ? q.hp - 1'b1 : q.hcnt - 1'b1;
        if (half_done) begin
          leading    = !q.edge_idx[0];
          last_bit   = (q.tx_bit == 5'(top_bit));
          d.sclk     = !q.sclk;
          d.edge_idx = q.edge_idx + 1'b1;
          own_cap    = leading ^ clock_phase_select;
          if (leading) begin
            if (clock_phase_select) begin
              for (int i = 0; i < smb_pkg::LANES; i++) begin
                d.dout[i]  = pick(q.tx_sh[i], lsb_first, top_bit);
                d.tx_sh[i] = shift(q.tx_sh[i], lsb_first);
              end
            end
          end else begin
            d.tx_bit = last_bit ? 5'h00 : q.tx_bit + 1'b1;
            if (last_bit && d.edge_idx != q.edge_tot) begin
              fifo_pop = fifo_valid; // underrun sends zeros rather than stall the clock
              for (int i = 0; i < smb_pkg::LANES; i++) begin
                d.tx_sh[i] = fifo_valid ? fifo_data[i*16 +: 16] : 16'h0000;
              end
            end else if (!last_bit && !clock_phase_select) begin
              for (int i = 0; i < smb_pkg::LANES; i++) begin
                d.tx_sh[i] = shift(q.tx_sh[i], lsb_first);
              end
            end
            if (!clock_phase_select) begin
              for (int i = 0; i < smb_pkg::LANES; i++) begin
                d.dout[i] = pick(d.tx_sh[i], lsb_first, top_bit);
              end
            end
          end
          if (d.edge_idx == q.edge_tot) begin
            d.state = smb_pkg::SMB_ST_TRAIL;
            d.phc   = {trail_periods, 1'b0};
          end
        end
      end
      smb_pkg::SMB_ST_TRAIL: begin
        d.hcnt = half_done ? q.hp - 1'b1 : q.hcnt - 1'b1;
        if (half_done) begin
          if (q.phc == '0) begin
            d.cs_n  = 1'b1;
            d.state = smb_pkg::SMB_ST_SETTLE;
            d.scnt  = smb_pkg::SETTLE_CYCLES;
          end else begin
            d.phc = q.phc - 1'b1;
          end
        end
      end
      smb_pkg::SMB_ST_SETTLE: begin
        // lets the last synchronised feedback edges and samples arrive
        if (q.scnt != '0) begin
          d.scnt = q.scnt - 1'b1;
        end else begin
          d.state = smb_pkg::SMB_ST_IDLE;
          d.busy  = 1'b0;
          if (!fb_enable || q.fb_cnt == q.edge_tot) begin
            d.valid  = 1'b1;
            d.rx_out = q.rx_hold;
          end else begin
            d.valid = 1'b0;
          end
        end
      end
      default: begin
        d.state = smb_pkg::SMB_ST_IDLE;
      end
    endcase

    // own-edge samples wait out the pin synchroniser delay
    d.cap_pipe = {q.cap_pipe[0], own_cap};
    // feedback suits round trips above half a period; longer needs more trail
    cap_now = fb_enable ? (fb_edge && (fb_s == cap_rise)) : q.cap_pipe[1];
    if (cap_now && q.busy) begin
      d.rx_bit = (q.rx_bit == 5'(top_bit)) ? 5'h00 : q.rx_bit + 1'b1;
      for (int i = 0; i < smb_pkg::LANES; i++) begin
        d.rx_sh[i] = lsb_first ? {pin_sync[i], q.rx_sh[i][15:1]}
                               : {q.rx_sh[i][14:0], pin_sync[i]};
        if (q.rx_bit == 5'(top_bit)) begin
          if (word_wide) begin
            d.rx_hold[i] = d.rx_sh[i];
          end else begin
            d.rx_hold[i] = {8'h00, lsb_first ? d.rx_sh[i][15:8] : d.rx_sh[i][7:0]};
          end
        end
      end
    end
    if (!fb_enable) begin
      d.valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q       <= '0;
      q.sclk  <= 1'b0;
      q.cs_n  <= 1'b1;
      q.valid <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sclk_o   = q.sclk;
  assign sclk_oe  = q.sclk_oe;
  assign cs_n_o   = q.cs_n;
  assign cs_n_oe  = q.cs_n_oe;
  assign dout_o   = q.dout;
  assign dout_oe  = q.dout_oe;
  assign rx_data  = q.rx_out;
  assign rx_valid = q.valid;
  assign busy     = q.busy;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_CS_LOW_IN_BURST: assert property (@(posedge sys_clk) disable iff (rst)
    (q.state == smb_pkg::SMB_ST_SHIFT || q.state == smb_pkg::SMB_ST_TRAIL) |-> !q.cs_n)
    else $error("chip select high during burst");

  AST_IDLE_LINES: assert property (@(posedge sys_clk) disable iff (rst)
    (q.state == smb_pkg::SMB_ST_IDLE && $past(q.state) == smb_pkg::SMB_ST_IDLE)
      |-> (q.cs_n && q.sclk == $past(clock_idle_level)))
    else $error("lines not idle between bursts");

  AST_EDGE_TOTAL: assert property (@(posedge sys_clk) disable iff (rst)
    (q.state == smb_pkg::SMB_ST_TRAIL && $past(q.state) == smb_pkg::SMB_ST_SHIFT)
      |-> (q.edge_idx == q.edge_tot && q.sclk == clock_idle_level))
    else $error("burst edge count wrong");

  AST_LEAD_QUIET: assert property (@(posedge sys_clk) disable iff (rst)
    (q.state == smb_pkg::SMB_ST_LEAD) ##1 (q.state != smb_pkg::SMB_ST_IDLE)
      |-> $stable(q.sclk))
    else $error("clock edge during lead delay");

  AST_TRAIL_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    (q.state == smb_pkg::SMB_ST_TRAIL && q.phc != '0) |=> (!q.cs_n && $stable(q.sclk)))
    else $error("chip select released early");

  AST_VALID_MATCH: assert property (@(posedge sys_clk) disable iff (rst)
    (q.state == smb_pkg::SMB_ST_SETTLE && q.scnt == '0 && fb_enable && q.fb_cnt == q.edge_tot)
      |=> (q.valid && q.rx_out == $past(q.rx_hold)))
    else $error("valid not raised on matching edges");

  AST_HOLD_MISMATCH: assert property (@(posedge sys_clk) disable iff (rst)
    (q.state == smb_pkg::SMB_ST_SETTLE && q.scnt == '0 && fb_enable && q.fb_cnt != q.edge_tot)
      |=> (!q.valid && $stable(q.rx_out)))
    else $error("mismatch did not hold data");

  AST_VALID_NO_FB: assert property (@(posedge sys_clk) disable iff (rst)
    !fb_enable |=> q.valid)
    else $error("valid low without feedback");

  AST_UNUSED_CS: assert property (@(posedge sys_clk) disable iff (rst)
    !cs_used |=> !q.cs_n_oe)
    else $error("unused chip select driven");

  AST_LANE_COUNT: assert property (@(posedge sys_clk) disable iff (rst)
    (lane_count < smb_pkg::LANES_MAX) |=> !q.dout_oe[smb_pkg::LANES-1])
    else $error("inactive lane driven");

endmodule

`default_nettype wire

// file: bench/smb_periph_model.sv
// serial peripheral model: answers a fixed word per lane, records lane zero
// assumes mode, length and order stay still while chip select is low
`default_nettype none

module smb_periph_model #(
  parameter logic [15:0] RET = 16'hA5C3
) (
  // serial pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  mosi,
  output logic      [3:0]  miso,
  output logic             fb_clk,
  // settings and commanded fault
  input  wire logic        idle_lvl,
  input  wire logic        phase,
  input  wire logic        wide,
  input  wire logic        lsb,
  input  wire logic        fb_drop,
  // last word seen on lane zero
  output logic      [15:0] cap
);
  timeunit 1ns;
  timeprecision 1ns;

  int         e = 0;
  logic [3:0] d;

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge cs_n) e = 0;

  always @(sclk) begin
    if (!cs_n) begin
      e = e + 1;
      if (sclk == (idle_lvl == phase)) begin
        cap = lsb ? {mosi[0], cap[15:1]} : {cap[14:0], mosi[0]};
      end
    end
  end

  // released lines show the inverse, so a stale sample cannot pass
  always @* begin
    logic [15:0] w;
    int          k;
    w = 16'h0000;
    k = 0;
    k = ((e - int'(phase)) / 2) % (wide ? 16 : 8);
    for (int l = 0; l < 4; l++) begin
      w = RET + 16'(l);
      d[l] = w[lsb ? k : (wide ? 15 : 7) - k];
    end
    miso = cs_n ? ~d : d;
  end

  // stuck feedback makes the edge count come out wrong
  assign fb_clk = fb_drop ? idle_lvl : sclk;

endmodule

`default_nettype wire

// file: bench/smb_master_tb.sv
// self-checking bench for the burst master against the peripheral model
// assumes 100 ns system clock; half period of 4 cycles gives an 800 ns link clock
`default_nettype none

module smb_master_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] RET = 16'hA5C3;
  logic        sys_clk = 1'b0, rst = 1'b1, step_trig = 1'b0, clock_idle_level = 1'b0;
  logic        clock_phase_select = 1'b0, word_wide = 1'b1, lsb_first = 1'b0;
  logic        fb_enable = 1'b0, cs_used = 1'b1, tx_valid = 1'b0, fb_drop = 1'b0, ps;
  logic [3:0]  dout_used = 4'hF;
  logic [6:0]  words_per_step = 7'h01;
  logic [1:0]  start_sel = 2'h0;
  logic [7:0]  lead_periods = 8'h00, trail_periods = 8'h00;
  logic [2:0]  lane_count = 3'h4;
  logic [23:0] manual_delay_cycles = 24'h000000, step_cycles = 24'h0000C8;
  logic [63:0] tx_data = 64'h0;
  logic        tx_ready, sclk_o, sclk_oe, cs_n_o, cs_n_oe, rx_valid, busy, fb_clk_i;
  logic [3:0]  dout_o, dout_oe, din_i;
  logic [63:0] rx_data;
  logic [15:0] cap;
  int          n_errors = 0, n_compared = 0, ne = 0, lc = 0, tc = 0, dc = 0, lc0, tc0, dc0;

  always #50 sys_clk = ~sys_clk;

  smb_master i_dut (.sys_clk, .rst, .step_trig, .clock_idle_level, .clock_phase_select,
    .word_wide, .lsb_first, .lane_count, .words_per_step, .start_sel,
    .manual_delay_cycles, .step_cycles, .lead_periods, .trail_periods,
    .half_period_ticks(16'h0064), .fb_enable, .sclk_used(1'b1), .cs_used, .dout_used,
    .tx_valid, .tx_ready, .tx_data, .sclk_o, .sclk_oe, .cs_n_o, .cs_n_oe, .dout_o,
    .dout_oe, .din_i, .fb_clk_i, .rx_data, .rx_valid, .busy);

  smb_periph_model #(.RET(RET)) i_per (.sclk(sclk_o), .cs_n(cs_n_o), .mosi(dout_o),
    .miso(din_i), .fb_clk(fb_clk_i), .idle_lvl(clock_idle_level), .phase(clock_phase_select),
    .wide(word_wide), .lsb(lsb_first), .fb_drop, .cap);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic push(input logic [63:0] d);
    logic rdy;
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    tx_data <= d;
    for (int i = 0; i < 100; i++) begin
      #1 rdy = tx_ready;
      @(posedge sys_clk);
      if (rdy === 1'b1) break;
      if (i == 99) begin n_errors++; report_and_stop; end
    end
    tx_valid <= 1'b0;
  endtask

  task automatic burst;
    @(posedge sys_clk);
    step_trig <= 1'b1;
    @(posedge sys_clk);
    step_trig <= 1'b0;
    for (int i = 0; i <= 20000; i++) begin
      @(posedge sys_clk);
      #1 if (busy === 1'b0) break;
      if (i == 20000) begin n_errors++; report_and_stop; end
    end
  endtask

  function automatic logic [63:0] expv(input logic w);
    for (int l = 0; l < 4; l++) expv[l*16+:16] = w ? RET + 16'(l) : {8'h00, 8'(RET + 16'(l))};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // edge, lead, trail and start delay counters per burst
  always @(posedge sys_clk) begin
    ps <= sclk_o;
    if (step_trig) begin ne <= 0; lc <= 0; tc <= 0; dc <= 0; end
    else if (busy === 1'b1 && cs_n_o === 1'b1) begin
      if (ne == 0) dc <= dc + 1;
      if (sclk_o !== ps) chk("edge_outside_cs", 1'b1, 1'b0);
    end
    else if (busy === 1'b1) begin
      if (sclk_o !== ps) begin ne <= ne + 1; tc <= 0; end
      else if (ne == 0) lc <= lc + 1;
      else tc <= tc + 1;
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int m = 0; m < 4; m++) begin
      clock_idle_level <= m[1];
      clock_phase_select <= m[0];
      lsb_first <= m[1] ^ m[0];
      push(64'h1111222233334C5A + 64'(m));
      burst;
      chk("edges", ne, 32);
      chk("rx", rx_data, expv(1'b1));
      chk("cap", cap, 16'h4C5A + 16'(m));
      chk("idle", sclk_o, m[1]);
      chk("cs_idle", cs_n_o, 1'b1);
      chk("valid", rx_valid, 1'b1);
    end
    word_wide <= 1'b0;
    words_per_step <= 7'h02;
    push(64'h0);
    push(64'h0);
    burst;
    chk("edges8", ne, 32);
    chk("rx8", rx_data, expv(1'b0));
    lc0 = lc;
    tc0 = tc;
    word_wide <= 1'b1;
    words_per_step <= 7'h01;
    lead_periods <= 8'h02;
    trail_periods <= 8'h03;
    push(64'h0);
    burst;
    chk("lead", lc - lc0, 16);
    chk("trail", tc - tc0, 24);
    dc0 = dc;
    lead_periods <= 8'h00;
    trail_periods <= 8'h00;
    manual_delay_cycles <= 24'h000032;
    for (int s = 1; s < 4; s++) begin
      start_sel <= 2'(s);
      push(64'h0);
      burst;
      chk("edges_start", ne, 32);
      // late start: step length less one 16-bit word of 8-cycle periods and settle
      if (s == 1) chk("late", dc - dc0, 68);
      if (s == 2) chk("manual", dc - dc0, 50);
    end
    start_sel <= 2'h0;
    fb_enable <= 1'b1;
    push(64'h0);
    burst;
    chk("fb_valid", rx_valid, 1'b1);
    chk("fb_rx", rx_data, expv(1'b1));
    fb_drop <= 1'b1;
    word_wide <= 1'b0;
    push(64'h0);
    burst;
    chk("fb_bad", rx_valid, 1'b0);
    chk("fb_hold", rx_data, expv(1'b1));
    fb_drop <= 1'b0;
    word_wide <= 1'b1;
    fb_enable <= 1'b0;
    words_per_step <= 7'h08;
    repeat (2) @(posedge sys_clk);
    #1 chk("valid_nofb", rx_valid, 1'b1);
    // model side stalls (no trigger) while the buffer fills
    for (int i = 0; i < 8; i++) push(64'(i) << 4);
    #1 chk("full", tx_ready, 1'b0);
    burst;
    chk("edges_fifo", ne, 256);
    chk("cap_last", cap, 16'h0070);
    chk("drained", tx_ready, 1'b1);
    lane_count <= 3'h2;
    repeat (2) @(posedge sys_clk);
    #1 chk("lanes_oe", dout_oe, 4'h3);
    chk("sclk_oe", sclk_oe, 1'b1);
    cs_used <= 1'b0;
    dout_used <= 4'h0;
    repeat (2) @(posedge sys_clk);
    #1 chk("cs_oe", cs_n_oe, 1'b0);
    chk("dout_oe", dout_oe, 4'h0);
    report_and_stop;
  end

endmodule

`default_nettype wire
